//--- hw/roct_defines.svh
// named constants for the residual overcurrent trip logic
// assumes a single system clock; included by bare name
`ifndef ROCT_DEFINES_SVH
`define ROCT_DEFINES_SVH
`define ROCT_CLK_HZ      50000000
`define ROCT_MS_PER_S    1000
`define ROCT_CYC_PER_MS  (`ROCT_CLK_HZ / `ROCT_MS_PER_S)
`define ROCT_FRAC_BITS   8
`define ROCT_RATIO_ONE   13'h0100
`define ROCT_RATIO_CLAMP 20
`define ROCT_HYST_PCT    95
`define ROCT_FULL_PCT    100
`define ROCT_TMS_SCALE   100
`define ROCT_TENTH_MS    10
`define ROCT_LN_MUL      227
`define ROCT_LN_SHIFT    6
`define ROCT_T_MAX       24'hFFFFFF
`define ROCT_ELAPSE_MAX  24'hFFFFFF
// curve constants, time in units of 0.1 ms
`define ROCT_K_IEC_INV   24'h000578
`define ROCT_K_IEC_VINV  24'h020F58
`define ROCT_K_IEC_EINV  24'h0C3500
`define ROCT_K_IEC_LINV  24'h124F80
`define ROCT_K_ANSI_INV  24'h000056
`define ROCT_K_ANSI_MINV 24'h000203
`define ROCT_K_ANSI_VINV 24'h02FE04
`define ROCT_K_ANSI_EINV 24'h044D90
`define ROCT_K_ANSI_LINV 24'h00035C
`define ROCT_K_ANSI_LVIN 24'h045B3C
`define ROCT_K_ANSI_LEIN 24'h09C6BC
`define ROCT_C_ANSI_INV  16'h00B9
`define ROCT_C_ANSI_MINV 16'h0474
`define ROCT_C_ANSI_VINV 16'h132E
`define ROCT_C_ANSI_EINV 16'h04C1
`define ROCT_C_ANSI_LINV 16'h073A
`define ROCT_C_ANSI_LVIN 16'h1BD0
`define ROCT_C_ANSI_LEIN 16'h09C4
`endif

//--- hw/roct_pkg.sv
// types shared by the residual overcurrent trip logic
// assumes nothing beyond a SystemVerilog package scope
package roct_pkg;
  // operation selection, off first so a zero input is disabled
  typedef enum logic [3:0] {
    ROCT_OP_OFF, ROCT_OP_DEFINITE,
    ROCT_OP_IEC_INV, ROCT_OP_IEC_VINV, ROCT_OP_IEC_EINV, ROCT_OP_IEC_LINV,
    ROCT_OP_ANSI_INV, ROCT_OP_ANSI_MINV, ROCT_OP_ANSI_VINV,
    ROCT_OP_ANSI_EINV, ROCT_OP_ANSI_LINV, ROCT_OP_ANSI_LVINV,
    ROCT_OP_ANSI_LEINV
  } roct_oper_t;
  // exponent class of an inverse curve
  typedef enum logic [1:0] {
    ROCT_A_002, ROCT_A_1, ROCT_A_2
  } roct_alpha_t;
endpackage

//--- hw/roct_top.sv
// residual overcurrent start/trip decision with definite and inverse timing
// assumes magnitude, settings and block come from logic on clk_sys_i
// Function
// - off, definite or eleven inverse curves; default off
// - start when magnitude exceeds percent threshold
// - definite mode trips after set delay
// - inverse time scaled by time multiplier
// - inverse trip never before minimum delay
// - inverse timing held for reset delay
// - trip status only after full delay while started
// - block input stops start and trip
// - start and trip status outputs
// - general start and trip from status
// - trip only when expired and unblocked
// - inverse needs curve and minimum both expired
// - curve delay fixed above twenty times threshold
// - per curve constants in operate formula
`timescale 1ns/10ps
`default_nettype none
`include "roct_defines.svh"
module roct_top
  import roct_pkg::*;
#(
  parameter int MAG_W      = 16,
  parameter int THR_W      = 11,
  parameter int TMS_W      = 11,
  parameter int DLY_W      = 16,
  parameter int CYC_PER_MS = `ROCT_CYC_PER_MS
) (
  input  wire logic             clk_sys_i,
  input  wire logic             arst_n_i,
  input  wire logic [MAG_W-1:0] residual_current_mag_i,
  input  wire logic [3:0]       operation_select_i,
  input  wire logic [THR_W-1:0] start_threshold_pct_i,
  input  wire logic [TMS_W-1:0] curve_time_multiplier_i,
  input  wire logic [DLY_W-1:0] definite_delay_ms_i,
  input  wire logic [DLY_W-1:0] inverse_min_delay_ms_i,
  input  wire logic [DLY_W-1:0] inverse_reset_delay_ms_i,
  input  wire logic             block_in_i,
  output var  logic             start_status_o,
  output var  logic             trip_status_o,
  output var  logic             general_start_out_o,
  output var  logic             general_trip_out_o
);
  localparam int TICK_W = $clog2(CYC_PER_MS);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYC_PER_MS - 1);
  localparam logic [12:0] RATIO_MAX =
    13'(`ROCT_RATIO_CLAMP * (1 << `ROCT_FRAC_BITS));

  roct_oper_t          oper_c;       // decoded operation setting
  logic                en_c;         // legal, non-off operation
  logic                fixed_c;      // definite time selected
  logic                run_c;        // enabled, not blocked, nonzero threshold
  logic [TICK_W-1:0]   tick_cnt_q;   // clocks within one ms
  logic                tick_q;       // one-cycle ms pulse
  logic                started_q;    // started state
  logic [23:0]         elapsed_ms_q; // accumulated operate time
  logic [DLY_W-1:0]    rst_cnt_q;    // ms spent in reset hold
  logic [12:0]         ratio_c;      // magnitude over threshold, q8
  logic [23:0]         k_c;          // curve multiplier, 0.1 ms
  logic [15:0]         c_c;          // curve offset, 0.1 ms
  roct_alpha_t         a_c;          // curve exponent class
  logic [31:0]         den_c;        // ratio^alpha - 1, q16
  logic [23:0]         t_tenth_c;    // operate time at unit multiplier
  logic [23:0]         t_tenth_q;    // registered operate time
  logic                expired_c;    // delay run out while started
  // setting decode; codes above the last curve are treated as off
  always_comb begin
    oper_c  = roct_oper_t'(operation_select_i);
    en_c    = (oper_c != ROCT_OP_OFF) && (oper_c <= ROCT_OP_ANSI_LEINV);
    fixed_c = (oper_c == ROCT_OP_DEFINITE);
    run_c   = en_c && !block_in_i && (start_threshold_pct_i != '0);
  end
  // millisecond time base, all delays count in these ticks
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q     <= 1'b0;
    end
  end
  // start with hysteresis so a current near the threshold cannot chatter
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      started_q <= 1'b0;
    end else if (!run_c) begin
      started_q <= 1'b0;
    end else if (residual_current_mag_i > MAG_W'(start_threshold_pct_i)) begin
      started_q <= 1'b1;
    end else if ((32'(residual_current_mag_i) * 32'(`ROCT_FULL_PCT)) <
                 (32'(start_threshold_pct_i) * 32'(`ROCT_HYST_PCT))) begin
      started_q <= 1'b0;
    end
  end
  // current ratio in q8, clamped at the end of the dependent range
  always_comb begin
    logic [31:0] quot;
    quot = ({16'h0000, residual_current_mag_i} << `ROCT_FRAC_BITS) /
           32'(start_threshold_pct_i | THR_W'(start_threshold_pct_i == '0));
    ratio_c = (quot > 32'(RATIO_MAX)) ? RATIO_MAX : quot[12:0];
  end
  // per-curve constants; ANSI curves carry an added offset
  always_comb begin
    k_c = `ROCT_K_IEC_INV;
    c_c = '0;
    a_c = ROCT_A_002;
    case (oper_c)
      ROCT_OP_IEC_VINV:   begin k_c = `ROCT_K_IEC_VINV;  a_c = ROCT_A_1; end
      ROCT_OP_IEC_EINV:   begin k_c = `ROCT_K_IEC_EINV;  a_c = ROCT_A_2; end
      ROCT_OP_IEC_LINV:   begin k_c = `ROCT_K_IEC_LINV;  a_c = ROCT_A_1; end
      ROCT_OP_ANSI_INV:   begin k_c = `ROCT_K_ANSI_INV;
                                c_c = `ROCT_C_ANSI_INV; end
      ROCT_OP_ANSI_MINV:  begin k_c = `ROCT_K_ANSI_MINV;
                                c_c = `ROCT_C_ANSI_MINV; end
      ROCT_OP_ANSI_VINV:  begin k_c = `ROCT_K_ANSI_VINV;
                                c_c = `ROCT_C_ANSI_VINV; a_c = ROCT_A_2; end
      ROCT_OP_ANSI_EINV:  begin k_c = `ROCT_K_ANSI_EINV;
                                c_c = `ROCT_C_ANSI_EINV; a_c = ROCT_A_2; end
      ROCT_OP_ANSI_LINV:  begin k_c = `ROCT_K_ANSI_LINV;
                                c_c = `ROCT_C_ANSI_LINV; end
      ROCT_OP_ANSI_LVINV: begin k_c = `ROCT_K_ANSI_LVIN;
                                c_c = `ROCT_C_ANSI_LVIN; a_c = ROCT_A_2; end
      ROCT_OP_ANSI_LEINV: begin k_c = `ROCT_K_ANSI_LEIN;
                                c_c = `ROCT_C_ANSI_LEIN; a_c = ROCT_A_2; end
      default:            begin k_c = `ROCT_K_IEC_INV; end
    endcase
  end
  // denominator; the 0.02 exponent uses a linear-mantissa log2,
  // which trades a few percent of curve accuracy for no multiplier tree
  always_comb begin
    logic [3:0]  msb;
    logic [12:0] norm;
    logic [15:0] lg;
    msb = 4'h0;
    for (int i = 0; i < 13; i++) begin
      if (ratio_c[i]) begin
        msb = 4'(i);
      end
    end
    norm = ratio_c << (4'd12 - msb);
    lg   = {4'(msb - 4'(`ROCT_FRAC_BITS)), norm[11:4], 4'h0} >> 4;
    den_c = '0;
    if (ratio_c > `ROCT_RATIO_ONE) begin
      case (a_c)
        ROCT_A_2: den_c = 32'(ratio_c) * 32'(ratio_c) - 32'h0001_0000;
        ROCT_A_1: den_c = 32'(ratio_c - `ROCT_RATIO_ONE) << `ROCT_FRAC_BITS;
        default:  den_c = (32'(lg) * 32'(`ROCT_LN_MUL)) >> `ROCT_LN_SHIFT;
      endcase
    end
  end
  // operate time k/den + c, saturated when the ratio is at or below one
  always_comb begin
    logic [47:0] t;
    t = '1;
    if (den_c != '0) begin
      t = ((48'(k_c) << 16) / 48'(den_c)) + 48'(c_c);
    end
    t_tenth_c = (t > 48'(`ROCT_T_MAX)) ? `ROCT_T_MAX : t[23:0];
  end
  // register the curve result to cut the divider path
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      t_tenth_q <= `ROCT_T_MAX;
    end else begin
      t_tenth_q <= t_tenth_c;
    end
  end
  // operate timer; inverse modes keep it through the reset delay
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      elapsed_ms_q <= '0;
      rst_cnt_q    <= '0;
    end else if (!run_c) begin
      elapsed_ms_q <= '0;
      rst_cnt_q    <= '0;
    end else if (started_q) begin
      rst_cnt_q <= '0;
      if (tick_q && (elapsed_ms_q != `ROCT_ELAPSE_MAX)) begin
        elapsed_ms_q <= elapsed_ms_q + 1'b1;
      end
    end else if (fixed_c || (elapsed_ms_q == '0)) begin
      elapsed_ms_q <= '0;
      rst_cnt_q    <= '0;
    end else if (tick_q) begin
      if ((rst_cnt_q + 1'b1) >= inverse_reset_delay_ms_i) begin
        elapsed_ms_q <= '0;
        rst_cnt_q    <= '0;
      end else begin
        rst_cnt_q <= rst_cnt_q + 1'b1;
      end
    end
  end
  // expiry: elapsed*1000 against t(0.1ms)*multiplier(0.01)
  always_comb begin
    logic def_exp;
    logic inv_exp;
    def_exp = elapsed_ms_q >= 24'(definite_delay_ms_i);
    inv_exp = ((40'(elapsed_ms_q) *
                40'(`ROCT_TENTH_MS * `ROCT_TMS_SCALE)) >=
               (40'(t_tenth_q) * 40'(curve_time_multiplier_i))) &&
              (elapsed_ms_q >= 24'(inverse_min_delay_ms_i));
    expired_c = started_q && run_c && (fixed_c ? def_exp : inv_exp);
  end
  // status and general outputs, all from flip-flops
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_status_o      <= 1'b0;
      trip_status_o       <= 1'b0;
      general_start_out_o <= 1'b0;
      general_trip_out_o  <= 1'b0;
    end else begin
      start_status_o      <= started_q && run_c;
      trip_status_o       <= expired_c;
      general_start_out_o <= start_status_o && run_c;
      general_trip_out_o  <= trip_status_o && run_c;
    end
  end
  // checks on the decision path
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  property p_off_quiet;
    !en_c |=> !start_status_o && !trip_status_o ##1 !general_trip_out_o;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("output active while operation is off");
  property p_block;
    block_in_i |=> !start_status_o && !trip_status_o;
  endproperty
  a_block: assert property (p_block)
    else $error("start or trip while blocked");
  property p_trip_needs_start;
    trip_status_o |-> start_status_o;
  endproperty
  a_trip_needs_start: assert property (p_trip_needs_start)
    else $error("trip without start");
  // run_c rather than en_c: a zero threshold also gates the general trip
  property p_general;
    (trip_status_o && run_c) |=> general_trip_out_o;
  endproperty
  a_general: assert property (p_general)
    else $error("general trip did not follow trip status");
  property p_def_delay;
    ($rose(trip_status_o) && $past(fixed_c)) |->
      $past(elapsed_ms_q) >= $past(24'(definite_delay_ms_i));
  endproperty
  a_def_delay: assert property (p_def_delay)
    else $error("definite trip before set delay");
  property p_min_delay;
    ($rose(trip_status_o) && !$past(fixed_c)) |->
      $past(elapsed_ms_q) >= $past(24'(inverse_min_delay_ms_i));
  endproperty
  a_min_delay: assert property (p_min_delay)
    else $error("inverse trip before minimum delay");
  property p_start_thr;
    $rose(started_q) |->
      $past(residual_current_mag_i > MAG_W'(start_threshold_pct_i));
  endproperty
  a_start_thr: assert property (p_start_thr)
    else $error("start without exceeding threshold");
  property p_hyst;
    ($fell(started_q) && $past(run_c)) |->
      $past((32'(residual_current_mag_i) * 32'(`ROCT_FULL_PCT)) <
            (32'(start_threshold_pct_i) * 32'(`ROCT_HYST_PCT)));
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("start dropped above hysteresis level");
  property p_clamp;
    ratio_c <= RATIO_MAX;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("ratio above clamp");
  property p_hold;
    (run_c && !started_q && !fixed_c && !tick_q && $past(run_c)) |=>
      $stable(elapsed_ms_q) || started_q || !run_c;
  endproperty
  a_hold: assert property (p_hold)
    else $error("inverse timing lost between ticks in reset hold");
  c_def_trip: cover property ($rose(trip_status_o) && fixed_c);
  c_inv_trip: cover property ($rose(trip_status_o) && !fixed_c);
  c_blocked:  cover property (start_status_o ##1 block_in_i);
  c_rehold:   cover property ($fell(started_q) && elapsed_ms_q != '0);
endmodule // roct_top
`default_nettype wire

//--- tb/roct_partner.sv
// partner: upstream magnitude stage and downstream trip consumer
// assumes the bench drives mag_req_i just after the clock edge
`timescale 1ns/10ps
`default_nettype none
module roct_partner (
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic [15:0] mag_req_i,
  input  wire logic        gen_trip_i,
  output logic      [15:0] mag_o,
  output logic      [7:0]  trips_o
);
  logic gen_d_q; // last trip command level
  // estimator output refreshed every clock, one cycle of latency
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mag_o <= 16'h0000;
    end else begin
      mag_o <= mag_req_i;
    end
  end
  // trip logic counts rising trip commands
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gen_d_q <= 1'b0;
      trips_o <= 8'h00;
    end else begin
      gen_d_q <= gen_trip_i;
      if (gen_trip_i && !gen_d_q) begin
        trips_o <= trips_o + 8'h01;
      end
    end
  end
endmodule // roct_partner
`default_nettype wire

//--- tb/test_roct_top.sv
// self-checking bench for the residual overcurrent trip logic
// assumes roct_partner stands in for magnitude stage and trip logic
`timescale 1ns/10ps
`default_nettype none
module test_roct_top;
  import roct_pkg::*;
  localparam int N = 10;            // cycles per ms, shortened for speed
  logic        clk_sys_i = 1'b0;    // 50 MHz system clock
  logic        arst_n_i  = 1'b0;    // reset held at start
  logic [15:0] mag_req   = 16'h0000; // magnitude asked of the estimator
  logic [15:0] mag;                 // estimator output
  logic [3:0]  op        = 4'h0;
  logic [10:0] thr       = 11'h032;
  logic [10:0] tms       = 11'h064;
  logic [15:0] dly       = 16'h0064;
  logic [15:0] mind      = 16'h0064;
  logic [15:0] rstd      = 16'h0064;
  logic        blk       = 1'b0;
  logic        st, tr, gst, gtr;
  logic [7:0]  trips;               // seen by the downstream model
  int bad_count = 0, checks_done = 0, seed = 32'h7F0B, cyc, lo, hi, i;
  // clamped curve time in ms at unit multiplier, index is the op code
  int crv [2:12] = '{2267, 711, 200, 6316, 158, 948, 540, 192, 1578,
                     784, 411};
  always #10 clk_sys_i = ~clk_sys_i;
  roct_top #(.CYC_PER_MS(N)) roct_top_inst (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .residual_current_mag_i(mag), .operation_select_i(op),
    .start_threshold_pct_i(thr), .curve_time_multiplier_i(tms),
    .definite_delay_ms_i(dly), .inverse_min_delay_ms_i(mind),
    .inverse_reset_delay_ms_i(rstd), .block_in_i(blk),
    .start_status_o(st), .trip_status_o(tr),
    .general_start_out_o(gst), .general_trip_out_o(gtr));
  roct_partner roct_partner_inst (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .mag_req_i(mag_req),
    .gen_trip_i(gtr), .mag_o(mag), .trips_o(trips));
  // inputs always move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chkr(input string nm, input int l, input int h,
                      input int v);
    checks_done++;
    if (v < l || v > h) begin
      bad_count++;
      $display("wrong value %s exp %0d..%0d got %0d", nm, l, h, v);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // cycles until trip status rises; a spent bound ends the run
  task automatic wait_trip(input int lim);
    cyc = 0;
    while (tr !== 1'b1) begin
      step(1);
      cyc++;
      if (cyc > lim) begin
        bad_count++;
        $display("wrong value trip_wait exp trip got none");
        conclude();
      end
    end
  endtask
  // pass through off so held inverse timing is cleared
  task automatic arm(input logic [3:0] o);
    mag_req = 16'h0000;
    op = 4'h0;
    step(3);
    op = o;
    step(2);
  endtask
  // expected inverse trip ms: curve and minimum both needed
  function automatic int exp_ms(input int o, input int t, input int m);
    int c;
    c = crv[o] * t / 100;
    return (c > m) ? c : m;
  endfunction
  initial begin
    step(6);
    chk("trip_status", 1'b0, tr);
    arst_n_i = 1'b1;
    // off and an unused code stay silent under heavy current
    for (i = 0; i < 2; i++) begin
      arm(i ? 4'hD : 4'h0);
      mag_req = 16'h03E8;
      step(20);
      chk("start_status", 1'b0, st);
      chk("general_trip", 1'b0, gtr);
    end
    $display("test off done");
    // definite time with random threshold and delay, first at edge
    for (i = 0; i < 3; i++) begin
      arm(4'h1);
      thr = 11'(10 + {$random(seed)} % 991);
      dly = 16'(40 + {$random(seed)} % 40);
      mag_req = 16'(thr) + 16'(i ? 1 + {$random(seed)} % 50 : 1);
      step(2);
      chk("start_status", 1'b0, st);
      step(1);
      chk("start_status", 1'b1, st);
      chk("general_start", 1'b0, gst);
      step(1);
      chk("general_start", 1'b1, gst);
      wait_trip(dly * N + 20);
      chkr("definite_cyc", (dly - 1) * N, dly * N + 6, cyc + 4);
      step(1);
      chk("general_trip", 1'b1, gtr);
      op = 4'h0;
      step(3);
      chk("trip_status", 1'b0, tr);
    end
    $display("test definite done");
    // hysteresis band then drop, then block while started
    arm(4'h1);
    mag_req = 16'(thr) + 16'h0064;
    step(4);
    mag_req = 16'((thr * 95 + 99) / 100);
    step(5);
    chk("start_status", 1'b1, st);
    mag_req = 16'((thr * 95 - 1) / 100);
    step(3);
    chk("start_status", 1'b0, st);
    mag_req = 16'(thr) + 16'h0064;
    step(4);
    blk = 1'b1;
    step(2);
    chk("start_status", 1'b0, st);
    step(1);
    chk("general_start", 1'b0, gst);
    step((dly + 5) * N);
    chk("trip_status", 1'b0, tr);
    blk = 1'b0;
    step(3);
    chk("start_status", 1'b1, st);
    $display("test hysteresis block done");
    // every inverse curve beyond twenty times threshold
    thr = 11'(20 + {$random(seed)} % 21);
    tms = 11'h014;
    mind = 16'h0064;
    for (i = 2; i <= 12; i++) begin
      arm(4'(i));
      mag_req = 16'(thr * 25);
      lo = exp_ms(i, 18, 100);
      hi = exp_ms(i, 22, 100);
      wait_trip(hi * N + 50);
      chkr("inverse_cyc", (lo - 1) * N, hi * N + 6, cyc);
      step(1);
      chk("general_trip", 1'b1, gtr);
    end
    $display("test inverse done");
    // reset delay: short gap resumes, long gap restarts
    arm(4'h3);
    tms = 11'h064;
    mind = 16'h0028;
    rstd = 16'h012C;
    mag_req = 16'(thr * 25);
    step(400 * N);
    chk("trip_status", 1'b0, tr);
    mag_req = 16'h0000;
    step(100 * N);
    mag_req = 16'(thr * 25);
    wait_trip(500 * N);
    chkr("resume_cyc", 230 * N, 390 * N, cyc);
    mag_req = 16'h0000;
    step(400 * N);
    mag_req = 16'(thr * 25);
    wait_trip(900 * N);
    chkr("restart_cyc", 630 * N, 790 * N, cyc);
    step(1);
    chk("general_trip", 1'b1, gtr);
    // downstream model saw 3 definite, 11 inverse and 2 reset-delay trips
    step(1);
    chkr("trip_count", 16, 16, trips);
    arst_n_i = 1'b0;
    #2;
    chk("trip_status", 1'b0, tr);
    $display("test reset delay done");
    conclude();
  end
endmodule // test_roct_top
`default_nettype wire
